//--- hw/hvp_consts.svh
// Named constants for the high-voltage port block: register indices,
// field positions, reset values and routing codes.
// Assumes inclusion by bare name from the package and the design file.
`ifndef HVP_CONSTS_SVH
`define HVP_CONSTS_SVH

// Register indices; the byte address is four times the index
`define HVP_IDX_PORTB    8'h01
`define HVP_IDX_DATA     8'h02
`define HVP_IDX_DDR      8'h06
`define HVP_IDX_CFG0     8'h25
`define HVP_IDX_CFG1     8'h26
`define HVP_IDX_STAT     8'h27
`define HVP_IDX_INTERRUPT_STATUS    8'h29

// Field positions
`define HVP_PORTB_CAP1   5
`define HVP_INTERRUPT_STATUS_CL4    6
`define HVP_ST_SIRQ      7
`define HVP_ST_SC6       6
`define HVP_ST_SC5       5

// Reset values
`define HVP_RST_BYTE     8'h00
`define HVP_RST_PIN7     7'h00
`define HVP_RST_SENSE5   5'h00

// Routing codes
`define HVP_PWM_PIN0     2'h1
`define HVP_PWM_PIN4     2'h2
`define HVP_PWM_PIN5     2'h3
`define HVP_TS_HI_PIN0   2'h1
`define HVP_TS_HI_PIN1   2'h2
`define HVP_TS_PIN4      3'h6
`define HVP_TS_PIN5      3'h7

`endif

//--- hw/hvp_pkg.sv
// Types shared by the high-voltage port block.
// Assumes the constants header sits beside it.
`default_nettype none
`include "hvp_consts.svh"
package hvp_pkg;
    // Port configuration register 0 layout
    typedef struct packed {
        logic       klineMode;
        logic       pin6PwmEn;
        logic [1:0] pwmPinSel;
        logic       pin3Compare2En;
        logic [2:0] timer1RouteSel;
    } hvp_cfg0_t;
    // Port configuration register 1 layout
    typedef struct packed {
        logic       senseIrqEn;
        logic       sinkShortIrqEn6;
        logic       sinkShortIrqEn5;
        logic [4:0] senseEn;
    } hvp_cfg1_t;
    // Timer and PWM signals entering the port
    typedef struct packed {
        logic pwm;
        logic compare1;
        logic compare2;
    } hvp_timer_t;
endpackage
`default_nettype wire

//--- hw/hvp_port.sv
// High-voltage port logic: contact sense, K-line pin, low-side drivers and
// PWM / timer routing, with an APB register slave.
// Assumes analog comparators and pin levels arrive asynchronously, timer
// and PWM signals come from logic on ref_clk, and the bench resolves pins.
//
// How it works
// - Each of pins 0 to 4 has its own sense enable bit.
// - Pin0 senses to supply, older pin4 to ground, pins 1-3 by data.
// - Low outside resistance reads as 1 in the sense result bit.
// - With direction clear, result is the inverted high-voltage input level.
// - Any enabled result change, either edge, sets the sense flag.
// - Sense request leaves the block only while its enable is set.
// - Pin4 as output biases the K-line driver; software sets the mode.
// - Current limit polarity depends on variant.
// - Pin4 routed to capture feeds the timer and the port B bit.
// - Low-side pins 5 and 6 follow data or PWM by routing; pin5 can also take compare 1.
// - Overcurrent turns the sink off, sets its flag, may interrupt.
// - A set sink flag holds the output off; writing 1 clears it.
// - K-line mode makes pin4 low-side only; no function on newer variant.
// - Pin6 PWM enable routes PWM onto pin6.
// - PWM select: none, pin0, pin4, pin5.
// - Compare 2 goes to pin3 when enabled; drive needs direction set.
// - Timer 1 select routes compare and chooses the capture pin.
// - Unrouted pins 0, 1, 4, 5 follow their data bits.
// - Shared pin: pins 0 and 4 take compare, pin5 takes PWM.
// - Sense flag stays set until a 1 is written to it.
`default_nettype none
`include "hvp_consts.svh"

// =====================================================================
// Three-stage input synchroniser with agreement filter
// =====================================================================
module hvp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,   // Sampling clock
    input  wire logic         rstN,  // Synchronised reset, active low
    input  wire logic [W-1:0] din,   // Asynchronous input
    output var  logic [W-1:0] dout   // Filtered, synchronised level
);
    logic [W-1:0] s1Q;
    logic [W-1:0] s2Q;
    logic [W-1:0] s3Q;

    // Level changes only once stages two and three agree
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            s1Q  <= '0;
            s2Q  <= '0;
            s3Q  <= '0;
            dout <= '0;
        end else begin
            s1Q  <= din;
            s2Q  <= s1Q;
            s3Q  <= s2Q;
            dout <= (s2Q & s3Q) | (dout & (s2Q | s3Q));
        end
    end
endmodule

// =====================================================================
// Port top
// =====================================================================
module hvp_port #(
    parameter bit NEW_VARIANT = 1'b0    // 1 selects the newer pin4 behaviour
) (
    input  wire logic              ref_clk,     // System clock, 20 MHz
    input  wire logic              rstn,        // Asynchronous reset, active low
    input  wire logic              psel,        // APB select
    input  wire logic              penable,     // APB access phase
    input  wire logic              pwrite,      // APB direction, 1 = write
    input  wire logic [11:0]       paddr,       // APB byte address
    input  wire logic [31:0]       pwdata,      // APB write data
    input  wire logic [3:0]        pstrb,       // APB byte strobes
    output var  logic [31:0]       prdata,      // APB read data
    output var  logic              pready,      // APB ready
    output var  logic              pslverr,     // APB error, unmapped address
    input  wire hvp_pkg::hvp_timer_t timerIn,   // PWM and compare signals
    input  wire logic [6:0]        pinIn,       // Pin levels from input block
    input  wire logic [4:0]        senseRaw,    // Sense comparators, 1 = low ohm
    input  wire logic              pin4OverCur, // Pin4 current above limit
    input  wire logic [1:0]        sinkOverCur, // Pins 5/6 drain overcurrent
    output var  logic [6:0]        pinOut,      // Pin drive level
    output var  logic [6:0]        pinOe,       // Pin drive enable, 1 = driving
    output var  logic [4:0]        senseOn,     // Sense circuit enable
    output var  logic [4:0]        senseToGnd,  // Sense direction, 1 = to ground
    output var  logic              klineBias,   // K-line driver bias enable
    output var  logic              capture1,    // Timer capture 1 input
    output var  logic              senseIrq,    // Contact sense request
    output var  logic              sinkIrq      // Sink short request
);
    import hvp_pkg::*;

    // =================================================================
    // Reset release
    // =================================================================
    logic rstMetaN;
    logic rstN;

    // Two flops so release never meets a clock edge mid-flight
    // Assertion is immediate; only the release waits for the clock
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rstMetaN <= 1'b0;
            rstN     <= 1'b0;
        end else begin
            rstMetaN <= 1'b1;
            rstN     <= rstMetaN;
        end
    end

    // =================================================================
    // Input synchronisers
    // =================================================================
    // All pin-side inputs are asynchronous; the filter
    // keeps one-cycle glitches off the flags
    logic [6:0] pinF;
    logic [4:0] senseF;
    logic [2:0] curF;

    hvp_sync #(.W(7)) uSyncPin (
        .clk(ref_clk), .rstN(rstN), .din(pinIn), .dout(pinF)
    );

    hvp_sync #(.W(5)) uSyncSense (
        .clk(ref_clk), .rstN(rstN), .din(senseRaw), .dout(senseF)
    );

    hvp_sync #(.W(3)) uSyncCur (
        .clk(ref_clk), .rstN(rstN), .din({pin4OverCur, sinkOverCur}), .dout(curF)
    );

    // =================================================================
    // Registers and APB decode
    // =================================================================
    logic [6:0] dataQ;
    logic [6:0] ddrQ;
    hvp_cfg0_t  cfg0Q;
    hvp_cfg1_t  cfg1Q;
    logic       senseFlagQ;
    logic [1:0] sinkFlagQ;     // [0] pin5, [1] pin6
    logic [4:0] resultQ;

    // Write takes effect only at the edge where pready is seen high
    wire        accDone = psel & penable & pready;
    wire [7:0]  idx     = paddr[9:2];
    wire        aligned = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0);
    wire        hitPortB = aligned & (idx == `HVP_IDX_PORTB);
    wire        hitData  = aligned & (idx == `HVP_IDX_DATA);
    wire        hitDdr   = aligned & (idx == `HVP_IDX_DDR);
    wire        hitCfg0  = aligned & (idx == `HVP_IDX_CFG0);
    wire        hitCfg1  = aligned & (idx == `HVP_IDX_CFG1);
    wire        hitStat  = aligned & (idx == `HVP_IDX_STAT);
    wire        hitIntsr = aligned & (idx == `HVP_IDX_INTERRUPT_STATUS);
    wire        mapped   = hitPortB | hitData | hitDdr | hitCfg0 | hitCfg1 | hitStat |
                           hitIntsr;
    // Unmapped words answer with an error and write nothing
    wire        wrEn     = accDone & pwrite & pstrb[0] & mapped;
    wire [7:0]  wb       = pwdata[7:0];

    // Newer variant reports 1 while below the limit
    wire        limitBit = NEW_VARIANT ? ~curF[2] : curF[2];

    wire [7:0] rdPortB = {2'h0, capture1, 5'h00};
    wire [7:0] rdStat  = {senseFlagQ, sinkFlagQ[1], sinkFlagQ[0], resultQ};
    wire [7:0] rdIntsr = {1'b0, limitBit, 6'h00};
    wire [7:0] rdByte  = hitPortB ? rdPortB :
                         hitData  ? {1'b0, dataQ} :
                         hitDdr   ? {1'b0, ddrQ} :
                         hitCfg0  ? cfg0Q :
                         hitCfg1  ? cfg1Q :
                         hitStat  ? rdStat :
                         hitIntsr ? rdIntsr : `HVP_RST_BYTE;

    // One wait state: ready rises in the second access cycle
    // Read data is registered so that it stands with pready
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            prdata  <= {24'h000000, rdByte};
        end
    end

    // Plain control registers
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            dataQ <= `HVP_RST_PIN7;
            ddrQ  <= `HVP_RST_PIN7;
            cfg0Q <= `HVP_RST_BYTE;
            cfg1Q <= `HVP_RST_BYTE;
        end else begin
            if (wrEn & hitData) dataQ <= wb[6:0];
            if (wrEn & hitDdr)  ddrQ  <= wb[6:0];
            if (wrEn & hitCfg0) cfg0Q <= wb;
            if (wrEn & hitCfg1) cfg1Q <= wb;
        end
    end

    // =================================================================
    // Contact sense
    // =================================================================
    // Direction clear means the input block drives the result
    // Results track even with sensing off, so enabling
    // a bit later never raises a stale flag
    wire [4:0] resultD  = (ddrQ[4:0] & senseF) | (~ddrQ[4:0] & ~pinF[4:0]);
    wire       senseHit = |((resultD ^ resultQ) & cfg1Q.senseEn);
    wire       w1cStat  = wrEn & hitStat;
    wire       senseClr = w1cStat & wb[`HVP_ST_SIRQ];

    // A change in the clearing cycle keeps the flag set
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            resultQ    <= `HVP_RST_SENSE5;
            senseFlagQ <= 1'b0;
        end else begin
            resultQ    <= resultD;
            senseFlagQ <= senseHit | (senseFlagQ & ~senseClr);
        end
    end

    // Pin0 fixed to supply; older pin4 fixed to ground
    wire       pin4Gnd = NEW_VARIANT ? dataQ[4] : 1'b1;
    wire [4:0] gndD    = {pin4Gnd, dataQ[3:1], 1'b0};

    // =================================================================
    // Low-side short protection
    // =================================================================
    wire [1:0] sinkClr = {w1cStat & wb[`HVP_ST_SC6], w1cStat & wb[`HVP_ST_SC5]};
    wire [1:0] sinkSet = curF[1:0] & pinOe[6:5];

    // Set wins over a simultaneous write-one clear
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            sinkFlagQ <= 2'h0;
        end else begin
            sinkFlagQ <= sinkSet | (sinkFlagQ & ~sinkClr);
        end
    end

    // =================================================================
    // PWM and timer routing
    // =================================================================
    wire [2:0] ts     = cfg0Q.timer1RouteSel;
    wire [1:0] ps     = cfg0Q.pwmPinSel;
    wire       cmp0   = (ts[2:1] == `HVP_TS_HI_PIN0);
    wire       cmp1   = (ts[2:1] == `HVP_TS_HI_PIN1);
    wire       cmp4   = (ts == `HVP_TS_PIN4);
    wire       cmp5   = (ts == `HVP_TS_PIN5);
    wire       pwm0   = (ps == `HVP_PWM_PIN0);
    wire       pwm4   = (ps == `HVP_PWM_PIN4);
    wire       pwm5   = (ps == `HVP_PWM_PIN5);
    // Code 110 is even yet still captures from pin4
    wire       capSrc4 = ts[0] | cmp4;

    // Compare wins on pins 0 and 4, PWM wins on pin5
    // Pin2 carries no special signal
    wire v0 = cmp0 ? timerIn.compare1 : pwm0 ? timerIn.pwm : dataQ[0];
    wire v1 = cmp1 ? timerIn.compare1 : dataQ[1];
    wire v3 = cfg0Q.pin3Compare2En ? timerIn.compare2 : dataQ[3];
    wire v4 = cmp4 ? timerIn.compare1 : pwm4 ? timerIn.pwm : dataQ[4];
    wire v5 = pwm5 ? timerIn.pwm : cmp5 ? timerIn.compare1 : dataQ[5];
    wire v6 = cfg0Q.pin6PwmEn ? timerIn.pwm : dataQ[6];

    // K-line mode drives pin4 only low; the newer variant ignores the bit
    wire lowOnly4 = cfg0Q.klineMode & ~NEW_VARIANT;
    wire [6:0] outD = {2'h0, v4, v3, dataQ[2], v1, v0};
    // Sink drivers only pull low, and a set flag holds them off
    // Gating on the set term spares the load a clock of full current
    wire [1:0] sinkOn = {v6, v5} & ddrQ[6:5] & ~sinkFlagQ & ~sinkSet;
    wire [6:0] oeD = {sinkOn, ddrQ[4] & ~(lowOnly4 & v4), ddrQ[3:0]};

    // Every output leaves through a flop
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            pinOut     <= `HVP_RST_PIN7;
            pinOe      <= `HVP_RST_PIN7;
            senseOn    <= `HVP_RST_SENSE5;
            senseToGnd <= `HVP_RST_SENSE5;
            klineBias  <= 1'b0;
            capture1   <= 1'b0;
            senseIrq   <= 1'b0;
            sinkIrq    <= 1'b0;
        end else begin
            pinOut     <= outD;
            pinOe      <= oeD;
            senseOn    <= cfg1Q.senseEn & ddrQ[4:0];
            senseToGnd <= gndD;
            klineBias  <= ddrQ[4];
            capture1   <= capSrc4 ? pinF[4] : pinF[0];
            senseIrq   <= senseFlagQ & cfg1Q.senseIrqEn;
            sinkIrq    <= |(sinkFlagQ & {cfg1Q.sinkShortIrqEn6, cfg1Q.sinkShortIrqEn5});
        end
    end

    // =================================================================
    // Checks
    // =================================================================
    // All checks sleep while the synchronised reset is low
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstN);

    // Sense flag and request
    a_irq_mask_gate: assert property (
        senseIrq |-> $past(cfg1Q.senseIrqEn) && $past(senseFlagQ))
        else $error("Sense request left while masked");

    a_sense_flag_set: assert property (
        senseHit |=> senseFlagQ)
        else $error("Enabled result change did not set the flag");

    a_sense_flag_hold: assert property (
        senseFlagQ && !senseClr |=> senseFlagQ)
        else $error("Sense flag dropped without a clear");

    a_sense_flag_clear: assert property (
        senseClr && !senseHit |=> !senseFlagQ)
        else $error("Write of one did not clear the sense flag");

    // Low-side protection
    a_sink_hold_off: assert property (
        sinkFlagQ[0] |=> !pinOe[5])
        else $error("Pin5 drove while its short flag was set");

    a_sink_trip: assert property (
        sinkSet[1] |=> sinkFlagQ[1] ##0 !pinOe[6])
        else $error("Pin6 overcurrent did not trip the driver");

    a_sink_flag_clear: assert property (
        sinkClr[0] && !sinkSet[0] |=> !sinkFlagQ[0])
        else $error("Write of one did not clear the pin5 flag");

    a_sink_irq_gate: assert property (
        sinkIrq |-> $past(|sinkFlagQ))
        else $error("Sink request without a short flag");

    // Routing and bus
    a_pin3_compare: assert property (
        cfg0Q.pin3Compare2En && !$changed(cfg0Q) |=> pinOut[3] == $past(timerIn.compare2))
        else $error("Pin3 does not follow compare 2");

    a_pin5_pwm_wins: assert property (
        pwm5 && cmp5 |=> pinOe[5] == 1'b0 || $past(timerIn.pwm))
        else $error("Pin5 drove without PWM while PWM was routed");

    a_pin0_compare: assert property (
        cmp0 |=> pinOut[0] == $past(timerIn.compare1))
        else $error("Pin0 does not follow compare 1");

    a_kline_low_only: assert property (
        lowOnly4 && v4 |=> !pinOe[4])
        else $error("Pin4 drove high in K-line mode");

    a_capture_route: assert property (
        ts == `HVP_TS_PIN4 |=> capture1 == $past(pinF[4]))
        else $error("Capture not taken from pin4");

    a_kline_bias: assert property (
        ##1 klineBias == $past(ddrQ[4]))
        else $error("K-line bias does not follow pin4 direction");

    a_apb_wait: assert property (
        psel && penable && !pready |=> pready)
        else $error("APB answer not given after one wait state");
endmodule
`default_nettype wire

//--- bench/hvp_far_side.sv
// Far-side model: contacts, loads and bus line on the high-voltage pins.
// Assumes the bench commands contact, outside level and short states.
`default_nettype none
// =====================================================================
// Pin and comparator model
// =====================================================================
module hvp_far_side (
    input  wire logic [6:0] pinOut,      // Level driven by the port
    input  wire logic [6:0] pinOe,       // Port drive enables
    input  wire logic [4:0] senseOn,     // Sense circuits switched on
    input  wire logic [4:0] swClosed,    // Commanded low-ohm contacts
    input  wire logic [6:0] extLevel,    // Outside level of released pins
    input  wire logic [2:0] shortCmd,    // Shorts on pins 4, 5 and 6
    output var  logic [6:0] pinIn,       // Resolved pin levels
    output var  logic [4:0] senseRaw,    // Comparator outputs
    output var  logic       pin4OverCur, // Pin4 current over limit
    output var  logic [1:0] sinkOverCur  // Sink drain overcurrent
);
    timeunit 1ns;
    timeprecision 1ns;
    // Released pins show the load's level, never the last driven one
    assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
    // A comparator that is switched off reads high resistance
    assign senseRaw = senseOn & swClosed;
    // Short current flows only while the driver is on
    assign pin4OverCur = shortCmd[0] & pinOe[4];
    assign sinkOverCur = shortCmd[2:1] & pinOe[6:5];
endmodule
`default_nettype wire

//--- bench/tb_hvp_port.sv
// Self-checking bench for the high-voltage port: APB tasks and directed
// sequences. Assumes hvp_pkg, hvp_port and hvp_far_side are compiled.
`default_nettype none
`include "hvp_consts.svh"
module tb_hvp_port;
    timeunit 1ns;
    timeprecision 1ns;
    import hvp_pkg::*;
    // =================================================================
    // Addresses and signals
    localparam logic [11:0] A_PB  = {2'b00, `HVP_IDX_PORTB, 2'b00};
    localparam logic [11:0] A_DAT = {2'b00, `HVP_IDX_DATA, 2'b00};
    localparam logic [11:0] A_DDR = {2'b00, `HVP_IDX_DDR, 2'b00};
    localparam logic [11:0] A_C0  = {2'b00, `HVP_IDX_CFG0, 2'b00};
    localparam logic [11:0] A_C1  = {2'b00, `HVP_IDX_CFG1, 2'b00};
    localparam logic [11:0] A_ST  = {2'b00, `HVP_IDX_STAT, 2'b00};
    localparam logic [11:0] A_IS  = {2'b00, `HVP_IDX_INTERRUPT_STATUS, 2'b00};
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    hvp_timer_t  timerIn = 3'b000;
    logic [6:0]  pinIn, pinOut, pinOe;
    logic [4:0]  senseRaw, senseOn, senseToGnd;
    logic        pin4OverCur, klineBias, capture1, senseIrq, sinkIrq;
    logic [1:0]  sinkOverCur;
    logic [31:0] prdata2, rdat2;
    logic [6:0]  pinOe2;
    logic [4:0]  senseToGnd2;
    logic [4:0]  swClosed = 5'h00;
    logic [6:0]  extLevel = 7'h7F;
    logic [2:0]  shortCmd = 3'h0;
    logic [31:0] rdat;
    logic        rerr;
    logic [6:0]  expd;
    logic        cap;
    int          nFail = 0;
    int          totalChecks = 0;
    int          cycles = 0;
    // Pins 5 and 6 are sinks, so their drive shows on the enable
    wire  logic [6:0] drv = {pinOe[6:5], pinOut[4:0]};

    hvp_port #(.NEW_VARIANT(1'b0)) hvp_port_inst (
        .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timerIn(timerIn), .pinIn(pinIn), .senseRaw(senseRaw),
        .pin4OverCur(pin4OverCur), .sinkOverCur(sinkOverCur),
        .pinOut(pinOut), .pinOe(pinOe), .senseOn(senseOn),
        .senseToGnd(senseToGnd), .klineBias(klineBias), .capture1(capture1),
        .senseIrq(senseIrq), .sinkIrq(sinkIrq));
    hvp_far_side hvp_far_side_inst (
        .pinOut(pinOut), .pinOe(pinOe), .senseOn(senseOn),
        .swClosed(swClosed), .extLevel(extLevel), .shortCmd(shortCmd),
        .pinIn(pinIn), .senseRaw(senseRaw), .pin4OverCur(pin4OverCur),
        .sinkOverCur(sinkOverCur));
    // Newer variant on the same bus; only its variant outputs are checked
    hvp_port #(.NEW_VARIANT(1'b1)) hvp_port_nv_inst (
        .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1),
        .prdata(prdata2), .pready(), .pslverr(), .timerIn(timerIn),
        .pinIn(pinIn), .senseRaw(senseRaw), .pin4OverCur(pin4OverCur),
        .sinkOverCur(sinkOverCur), .pinOut(), .pinOe(pinOe2), .senseOn(),
        .senseToGnd(senseToGnd2), .klineBias(), .capture1(), .senseIrq(),
        .sinkIrq());

    // =================================================================
    // Clock, hang guard and shared tasks
    always #25 ref_clk = ~ref_clk;
    // The whole run needs about 600 cycles; 6000 means a hang
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            nFail = nFail + 1;
            wrapUp();
        end
    end
    task automatic wrapUp();
        $display("Checks %0d, mismatches %0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        totalChecks++;
        if (got !== exp) begin
            nFail++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; idle cycle first so no signal changes twice
    task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rdat = prdata;
        rdat2 = prdata2;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        xfer(a, 1'b0, 8'h00);
        chk(rdat[7:0], exp);
    endtask
    // Input synchronisers need about four edges
    task automatic settle();
        repeat (8) @(posedge ref_clk);
    endtask

    // =================================================================
    // Directed sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        // Reset contents and an unmapped word
        rd(A_DDR, 8'h00);
        rd(A_C0, 8'h00);
        rd(A_C1, 8'h00);
        rd(A_ST, 8'h00);
        rd(A_IS, 8'h00);
        chk(rdat2[7:0], 8'h40);
        xfer(12'h0FC, 1'b0, 8'h00);
        chk(8'(rerr), 8'h01);
        // Contact sense with pins 0-4 as outputs
        wr(A_DAT, 8'h13);
        wr(A_DDR, 8'h1F);
        wr(A_C1, 8'h9F);
        settle();
        chk(8'(senseOn), 8'h1F);
        chk(8'(senseToGnd), 8'h12);
        chk(8'(drv[4:0]), 8'h13);
        chk(8'(klineBias), 8'h01);
        swClosed <= 5'h04;
        settle();
        rd(A_ST, 8'h84);
        chk(8'(senseIrq), 8'h01);
        wr(A_ST, 8'h00);
        rd(A_ST, 8'h84);
        wr(A_ST, 8'h80);
        rd(A_ST, 8'h04);
        swClosed <= 5'h00;
        settle();
        rd(A_ST, 8'h80);
        wr(A_C1, 8'h1F);
        settle();
        chk(8'(senseIrq), 8'h00);
        wr(A_ST, 8'h80);
        // Pin1 as input: result follows the inverted input level
        wr(A_DDR, 8'h1D);
        extLevel <= 7'h7D;
        settle();
        rd(A_ST, 8'h82);
        extLevel <= 7'h7F;
        settle();
        rd(A_ST, 8'h80);
        wr(A_ST, 8'h80);
        wr(A_C1, 8'h00);
        // K-line mode and current limit on pin4
        wr(A_DDR, 8'h1F);
        wr(A_C0, 8'h80);
        settle();
        chk(8'(pinOe[4]), 8'h00);
        chk(8'(pinOe2[4]), 8'h01);
        wr(A_DAT, 8'h03);
        settle();
        chk(8'({pinOe[4], pinOut[4], klineBias}), 8'h05);
        chk(8'(senseToGnd2[4]), 8'h00);
        shortCmd <= 3'h1;
        settle();
        rd(A_IS, 8'h40);
        chk(rdat2[7:0], 8'h00);
        wr(A_DDR, 8'h0F);
        shortCmd <= 3'h0;
        // PWM routing through every select code
        wr(A_DAT, 8'h00);
        wr(A_DDR, 8'h7F);
        timerIn <= 3'b100;
        for (int s = 0; s < 4; s++) begin
            wr(A_C0, {1'b0, s[0], s[1:0], 4'h0});
            settle();
            expd = {s[0], s == 3, s == 2, 3'b000, s == 1};
            chk(8'(drv & 7'h71), 8'(expd));
        end
        // Timer 1 compare routing through every code
        timerIn <= 3'b010;
        for (int c = 0; c < 8; c++) begin
            wr(A_C0, {5'h00, c[2:0]});
            settle();
            expd = {1'b0, c == 7, c == 6, 2'b00, c == 4 || c == 5, c == 2 || c == 3};
            chk(8'(drv & 7'h33), 8'(expd));
        end
        // Shared pins: compare wins on 0 and 4, PWM wins on 5
        timerIn <= 3'b100;
        wr(A_C0, 8'h12);
        settle();
        chk(8'(drv[0]), 8'h00);
        wr(A_C0, 8'h26);
        settle();
        chk(8'(drv[4]), 8'h00);
        wr(A_C0, 8'h37);
        settle();
        chk(8'(drv[5]), 8'h01);
        // Compare 2 on pin3 drives only with direction set
        timerIn <= 3'b001;
        wr(A_C0, 8'h08);
        settle();
        chk(8'({pinOe[3], pinOut[3]}), 8'h03);
        wr(A_DDR, 8'h77);
        settle();
        chk(8'(pinOe[3]), 8'h00);
        // Capture source per code, pin0 high and pin4 low
        wr(A_DDR, 8'h00);
        extLevel <= 7'h6F;
        for (int c = 0; c < 8; c++) begin
            wr(A_C0, {5'h00, c[2:0]});
            settle();
            cap = (c != 6) && (c % 2 == 0);
            chk(8'(capture1), 8'(cap));
            rd(A_PB, {2'b00, cap, 5'h00});
        end
        // Sink short: off, flagged, held off until cleared
        extLevel <= 7'h7F;
        wr(A_C0, 8'h00);
        wr(A_DAT, 8'h60);
        wr(A_DDR, 8'h60);
        wr(A_C1, 8'h20);
        settle();
        chk(8'(pinOe[6:5]), 8'h03);
        shortCmd <= 3'h6;
        settle();
        chk(8'({pinOe[6:5], sinkIrq}), 8'h01);
        rd(A_ST, 8'h60);
        shortCmd <= 3'h0;
        settle();
        chk(8'(pinOe[6:5]), 8'h00);
        wr(A_ST, 8'h20);
        settle();
        chk(8'({pinOe[6:5], sinkIrq}), 8'h02);
        wr(A_ST, 8'h40);
        rd(A_ST, 8'h00);
        wrapUp();
    end
endmodule
`default_nettype wire
